//--- inc/esv_pkg.sv
// Shared constants and types for the exception status and vectoring unit.
// Assumes a 16-bit logical address space and a 24-bit physical table space.
package esv_pkg;
  localparam int          PSW_W          = 16;
  localparam int          OFF_W          = 10;
  localparam int          PHYS_W         = 24;
  localparam int          PSW_SS_BIT     = 8;
  localparam int          PSW_USER_BIT   = 14;
  localparam int          ISR_VEC_A_BIT  = 13;
  localparam int          ISR_VEC_B_BIT  = 14;
  localparam int          ISR_VEC_C_BIT  = 15;
  localparam logic [15:0] PSW_IRQ_MASK   = 16'h007F;
  localparam logic [15:0] PSW_RST        = 16'h0000;
  localparam logic [15:0] PC_NMI         = 16'h0066;
  localparam logic [15:0] PC_MODE1       = 16'h0038;
  localparam logic [9:0]  OFF_NMI        = 10'h004;
  localparam logic [9:0]  OFF_LINE_A     = 10'h008;
  localparam logic [9:0]  OFF_LINE_B     = 10'h00C;
  localparam logic [9:0]  OFF_LINE_C     = 10'h010;
  localparam logic [9:0]  LIST_A         = 10'h070;
  localparam logic [9:0]  LIST_B         = 10'h170;
  localparam logic [9:0]  LIST_C         = 10'h270;
  localparam logic [9:0]  PC_WORD_OFF    = 10'h002;
  localparam logic [15:0] STACK_WORD     = 16'h0002;

  typedef enum logic [2:0] {
    SRC_NMI,
    SRC_LINE_A,
    SRC_LINE_B,
    SRC_LINE_C,
    SRC_ONCHIP,
    SRC_TRAP
  } esv_src_t;

  typedef enum logic [1:0] {
    RET_NMI,
    RET_MASKABLE,
    RET_LONG
  } esv_ret_t;
endpackage

//--- src/esv_vec_calc.sv
// Table offset calculator for the status word and program counter entries.
// Assumes the caller supplies the fixed offset for on-chip sources and traps.
`timescale 1ns/100ps
module esv_vec_calc #(
  parameter int OFF_BITS = 10
) (
  input  esv_pkg::esv_src_t src,
  input  logic [15:0]       isr,
  input  logic [7:0]        vec,
  input  logic [9:0]        fixed_off,
  output logic [9:0]        psw_off,
  output logic [9:0]        pc_off
);
  import esv_pkg::*;

  if (OFF_BITS != OFF_W) begin : g_bad_width
    $error("esv_vec_calc supports only the fixed offset width");
  end

  logic [9:0] vec_even;

  // Odd vectors would land in the middle of a counter word, so the low bit is dropped.
  assign vec_even = {2'b00, vec[7:1], 1'b0};

  always_comb begin
    psw_off = fixed_off;
    pc_off  = fixed_off + PC_WORD_OFF;
    case (src)
      SRC_NMI: begin
        psw_off = OFF_NMI;
        pc_off  = isr[ISR_VEC_A_BIT] ? LIST_A + vec_even : OFF_NMI + PC_WORD_OFF; // RQ10
      end
      SRC_LINE_A: begin
        psw_off = OFF_LINE_A;
        pc_off  = isr[ISR_VEC_A_BIT] ? LIST_A + vec_even : OFF_LINE_A + PC_WORD_OFF; // RQ12
      end
      SRC_LINE_B: begin
        psw_off = OFF_LINE_B;
        pc_off  = isr[ISR_VEC_B_BIT] ? LIST_B + vec_even : OFF_LINE_B + PC_WORD_OFF; // RQ7
      end
      SRC_LINE_C: begin
        psw_off = OFF_LINE_C;
        pc_off  = isr[ISR_VEC_C_BIT] ? LIST_C + vec_even : OFF_LINE_C + PC_WORD_OFF; // RQ9
      end
      default: begin
        psw_off = fixed_off;
        pc_off  = fixed_off + PC_WORD_OFF; // RQ11
      end
    endcase
  end
endmodule // esv_vec_calc

//--- src/esv_psw_calc.sv
// Status word rewrites for non-table interrupt entry and nonmaskable return.
// Assumes the interrupt request enable bits sit in the low seven bits.
`timescale 1ns/100ps
module esv_psw_calc (
  input  logic [15:0] psw,
  input  logic [6:0]  irq_shadow,
  output logic [15:0] forced_psw,
  output logic [15:0] shadow_psw
);
  import esv_pkg::*;

  logic [15:0] clear_mask;

  assign clear_mask = PSW_IRQ_MASK | (16'h0001 << PSW_SS_BIT) | (16'h0001 << PSW_USER_BIT);
  assign forced_psw = psw & ~clear_mask; // RQ1
  assign shadow_psw = (psw & ~PSW_IRQ_MASK) | {9'h000, irq_shadow}; // RQ16
endmodule // esv_psw_calc

//--- src/esv_exception_unit.sv
// Exception entry and return sequencer: loads the new status word and program counter.
// Assumes status saving is done by the core before entry_req, and that memory answers
// every word read with one mem_rvalid pulse.
//
// Contract
// (RQ1) Modes 0-2 external entry forces system mode, single-step off, maskables off.
// (RQ2) Mode 3, on-chip and trap entries fetch the status word from the table.
// (RQ3) In mode 0 the peripheral supplies a call or restart instruction.
// (RQ4) Mode 0 nonmaskable loads program counter 0066 and disables maskables.
// (RQ5) Mode 1 loads 0038 for maskable, 0066 for nonmaskable.
// (RQ6) Mode 2 maskable reads the counter at vector page joined with vector.
// (RQ7) Mode 3 lines are vectored or fixed per interrupt status bits.
// (RQ8) A table entry is the status word, then the program counter.
// (RQ9) Vectored entries index up to 128 counters by even vector.
// (RQ10) Nonmaskable shares the line A vector list.
// (RQ11) Counter/timer 0 takes status at 14 and counter at 16, identifier 14.
// (RQ12) Line A takes status at 08, counter at 0A or 70 plus vector.
// (RQ13) The loaded counter is a logical address for the first fetch.
// (RQ14) After modes 0-2 maskables stay off until an allowed instruction changes them.
// (RQ15) All three return instructions are privileged.
// (RQ16) Nonmaskable return pops the counter and restores enables from the shadow.
// (RQ17) Maskable return pops the counter and fetches its opcode uncached.
// (RQ18) Long return pops status word and counter, no special bus activity.
// (RQ19) Mode 3 and trap routines drop trap data before the long return.
// (RQ20) Peripherals return even vectors for vectored acknowledges.
// (RQ21) The table base is the 12-bit pointer on a 4K boundary.
// (RQ22) All table reads finish before the first service routine fetch.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module esv_exception_unit (
  input  logic              clk,
  input  logic              rst,
  input  logic              entry_req,
  input  esv_pkg::esv_src_t entry_src,
  input  logic [1:0]        int_mode,
  input  logic [15:0]       ack_data,
  input  logic [9:0]        fixed_off,
  input  logic [15:0]       isr,
  input  logic [7:0]        vec_page,
  input  logic [11:0]       tbl_ptr,
  input  logic              ret_req,
  input  esv_pkg::esv_ret_t ret_kind,
  input  logic [15:0]       sp,
  input  logic              psw_wr,
  input  logic [15:0]       psw_wdata,
  input  logic [6:0]        irq_shadow,
  input  logic [15:0]       mem_rdata,
  input  logic              mem_rvalid,
  output logic              mem_rd,
  output logic [23:0]       mem_addr,
  output logic              mem_logical,
  output logic [15:0]       psw,
  output logic [15:0]       pc,
  output logic              pc_load,
  output logic [15:0]       reason,
  output logic              fetch_go,
  output logic              fetch_uncached,
  output logic              m0_inject,
  output logic              priv_fault,
  output logic [1:0]        pop_words,
  output logic              busy
);
  import esv_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_TBL_PSW,
    S_TBL_PC,
    S_M2_PC,
    S_POP_FIRST,
    S_POP_SECOND
  } esv_state_t;

  esv_state_t  state;
  esv_ret_t    ret_cur;
  logic [9:0]  psw_off;
  logic [9:0]  pc_off;
  logic [9:0]  pc_off_hold;
  logic [15:0] sp_cur;
  logic [15:0] forced_psw;
  logic [15:0] shadow_psw;
  logic        is_ext;
  logic        is_nmi;
  logic        idle_entry;
  logic        idle_ret;
  logic        user_mode;

  esv_vec_calc #(
    .OFF_BITS (OFF_W)
  ) u_vec (
    .src       (entry_src),
    .isr       (isr),
    .vec       (ack_data[7:0]),
    .fixed_off (fixed_off),
    .psw_off   (psw_off),
    .pc_off    (pc_off)
  );

  esv_psw_calc u_psw (
    .psw        (psw),
    .irq_shadow (irq_shadow),
    .forced_psw (forced_psw),
    .shadow_psw (shadow_psw)
  );

  assign is_ext     = (entry_src == SRC_NMI) || (entry_src == SRC_LINE_A) ||
                      (entry_src == SRC_LINE_B) || (entry_src == SRC_LINE_C);
  assign is_nmi     = (entry_src == SRC_NMI);
  assign idle_entry = (state == S_IDLE) && entry_req;
  assign idle_ret   = (state == S_IDLE) && !entry_req && ret_req;
  assign user_mode  = psw[PSW_USER_BIT];

  // Sequencer and memory read port; a read stays up until its word arrives.
  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= S_IDLE;
      ret_cur     <= RET_NMI;
      pc_off_hold <= 10'h000;
      sp_cur      <= 16'h0000;
      mem_rd      <= 1'b0;
      mem_addr    <= 24'h000000;
      mem_logical <= 1'b0;
      busy        <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (entry_req) begin
            if (is_ext && int_mode == 2'd2 && !is_nmi) begin
              state       <= S_M2_PC;
              mem_rd      <= 1'b1;
              mem_addr    <= {8'h00, vec_page, ack_data[7:0]}; // RQ6
              mem_logical <= 1'b1;
              busy        <= 1'b1;
            end else if (!is_ext || int_mode == 2'd3) begin
              state       <= S_TBL_PSW; // RQ2
              pc_off_hold <= pc_off;
              mem_rd      <= 1'b1;
              mem_addr    <= {tbl_ptr, 2'b00, psw_off}; // RQ21
              mem_logical <= 1'b0;
              busy        <= 1'b1;
            end
          end else if (ret_req && !user_mode) begin
            state       <= S_POP_FIRST;
            ret_cur     <= ret_kind;
            sp_cur      <= sp;
            mem_rd      <= 1'b1;
            mem_addr    <= {8'h00, sp};
            mem_logical <= 1'b1;
            busy        <= 1'b1;
          end
        end
        S_TBL_PSW: begin
          if (mem_rvalid) begin
            state    <= S_TBL_PC; // RQ8
            mem_addr <= {tbl_ptr, 2'b00, pc_off_hold};
          end
        end
        S_POP_FIRST: begin
          if (mem_rvalid) begin
            if (ret_cur == RET_LONG) begin
              state    <= S_POP_SECOND; // RQ18
              mem_addr <= {8'h00, sp_cur + STACK_WORD};
            end else begin
              state  <= S_IDLE;
              mem_rd <= 1'b0;
              busy   <= 1'b0;
            end
          end
        end
        default: begin
          if (mem_rvalid) begin
            state  <= S_IDLE;
            mem_rd <= 1'b0;
            busy   <= 1'b0;
          end
        end
      endcase
    end
  end

  // Status word owner; only these paths may change it, so maskables stay off otherwise.
  always_ff @(posedge clk) begin
    if (rst) begin
      psw <= PSW_RST;
    end else if (idle_entry && is_ext && int_mode != 2'd3) begin
      psw <= forced_psw; // RQ1
    end else if (state == S_TBL_PSW && mem_rvalid) begin
      psw <= mem_rdata; // RQ2
    end else if (state == S_POP_FIRST && mem_rvalid && ret_cur == RET_LONG) begin
      psw <= mem_rdata; // RQ18
    end else if (state == S_POP_FIRST && mem_rvalid && ret_cur == RET_NMI) begin
      psw <= shadow_psw; // RQ16
    end else if (state == S_IDLE && psw_wr) begin
      psw <= psw_wdata; // RQ14
    end
  end

  // Program counter, identifier word and one-cycle completion pulses.
  always_ff @(posedge clk) begin
    if (rst) begin
      pc             <= 16'h0000;
      pc_load        <= 1'b0;
      reason         <= 16'h0000;
      fetch_go       <= 1'b0;
      fetch_uncached <= 1'b0;
      m0_inject      <= 1'b0;
      priv_fault     <= 1'b0;
      pop_words      <= 2'd0;
    end else begin
      pc_load        <= 1'b0;
      fetch_go       <= 1'b0;
      fetch_uncached <= 1'b0;
      m0_inject      <= 1'b0;
      priv_fault     <= idle_ret && user_mode; // RQ15
      pop_words      <= 2'd0;
      if (idle_entry) begin
        reason <= is_ext ? ack_data : {6'h00, fixed_off}; // RQ11
        if (is_ext && int_mode != 2'd3 && is_nmi) begin
          pc       <= PC_NMI; // RQ4
          pc_load  <= 1'b1;
          fetch_go <= 1'b1;
        end else if (is_ext && int_mode == 2'd1) begin
          pc       <= PC_MODE1; // RQ5
          pc_load  <= 1'b1;
          fetch_go <= 1'b1;
        end else if (is_ext && int_mode == 2'd0) begin
          m0_inject <= 1'b1; // RQ3
        end
      end else if (mem_rvalid && (state == S_TBL_PC || state == S_M2_PC)) begin
        pc       <= mem_rdata; // RQ13
        pc_load  <= 1'b1;
        fetch_go <= 1'b1; // RQ22
      end else if (mem_rvalid && state == S_POP_FIRST && ret_cur != RET_LONG) begin
        pc             <= mem_rdata;
        pc_load        <= 1'b1;
        fetch_go       <= 1'b1;
        fetch_uncached <= (ret_cur == RET_MASKABLE); // RQ17
        pop_words      <= 2'd1;
      end else if (mem_rvalid && state == S_POP_SECOND) begin
        pc        <= mem_rdata;
        pc_load   <= 1'b1;
        fetch_go  <= 1'b1;
        pop_words <= 2'd2;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_tbl_start;
    idle_entry && (!is_ext || int_mode == 2'd3);
  endsequence

  sequence s_psw_read;
    mem_rd && !mem_logical && mem_addr == {tbl_ptr, 2'b00, $past(psw_off)};
  endsequence

  nmi_entry_pc_a: assert property (idle_entry && is_nmi && int_mode != 2'd3 |=> // RQ4
    pc == 16'h0066 && pc_load && fetch_go && psw[6:0] == 7'h00)
    else $error("nonmaskable entry did not load 0066");

  mode1_pc_a: assert property (idle_entry && is_ext && !is_nmi && int_mode == 2'd1 |=> // RQ5
    pc == 16'h0038 && pc_load)
    else $error("mode 1 entry did not load 0038");

  forced_psw_a: assert property (idle_entry && is_ext && int_mode != 2'd3 |=> // RQ1
    psw[6:0] == 7'h00 && !psw[PSW_SS_BIT] && !psw[PSW_USER_BIT])
    else $error("status word not forced to system mode");

  tbl_psw_read_a: assert property (s_tbl_start |=> s_psw_read) // RQ2
    else $error("table status read at wrong address");

  mode2_addr_a: assert property (idle_entry && is_ext && !is_nmi && int_mode == 2'd2 |=> // RQ6
    mem_rd && mem_logical && mem_addr[15:0] == {$past(vec_page), $past(ack_data[7:0])})
    else $error("mode 2 vector address wrong");

  entry_order_a: assert property (state == S_TBL_PSW && mem_rvalid |=> // RQ8
    state == S_TBL_PC && mem_addr[9:0] == $past(pc_off_hold) && !fetch_go)
    else $error("counter read did not follow status read");

  fetch_last_a: assert property (fetch_go |-> !mem_rd && !busy) // RQ22
    else $error("service fetch started with table reads pending");

  priv_ret_a: assert property (idle_ret && user_mode |=> priv_fault && state == S_IDLE) // RQ15
    else $error("user mode return not refused");

  return_from_nmi_shadow_a: assert property (state == S_POP_FIRST && mem_rvalid && ret_cur == RET_NMI |=> // RQ16
    psw[6:0] == $past(irq_shadow) && pc == $past(mem_rdata))
    else $error("nonmaskable return did not restore enables");

  return_from_maskable_uncached_a: assert property (state == S_POP_FIRST && mem_rvalid && ret_cur == RET_MASKABLE |=> // RQ17
    fetch_uncached && fetch_go && pop_words == 2'd1)
    else $error("maskable return fetch not uncached");

  return_long_with_status_plain_a: assert property (state == S_POP_SECOND && mem_rvalid |=> // RQ18
    fetch_go && !fetch_uncached && pop_words == 2'd2)
    else $error("long return showed special bus activity");

  psw_hold_a: assert property (state == S_IDLE && !entry_req && !psw_wr |=> // RQ14
    psw == $past(psw) || $past(ret_req))
    else $error("status word changed without a permitted cause");
endmodule // esv_exception_unit

//--- tb/esv_mem_model.sv
// Behavioural memory that holds the vector table and the system stack.
// Assumes one read at a time, with mem_rd held until mem_rvalid is returned.
`timescale 1ns/100ps
module esv_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mem_rd,
  input  wire logic [23:0] mem_addr,
  input  wire logic [2:0]  lat,
  output logic             mem_rvalid,
  output logic [15:0]      mem_rdata
);
  logic [2:0] cnt;

  // Each word is its own low address with the bytes swapped, so a wrong address shows as a wrong value.
  // Outside an answer the data toggle every cycle, so a late capture cannot pass by luck.
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rvalid <= 1'b0;
      cnt        <= 3'h0;
      mem_rdata  <= 16'hA5A5;
    end else if (!mem_rvalid && mem_rd && cnt >= lat - 3'h1) begin
      mem_rvalid <= 1'b1;
      cnt        <= 3'h0;
      mem_rdata  <= {mem_addr[7:0], mem_addr[15:8]};
    end else begin
      mem_rvalid <= 1'b0;
      cnt        <= (mem_rd && !mem_rvalid) ? cnt + 3'h1 : 3'h0;
      mem_rdata  <= ~mem_rdata;
    end
  end
endmodule // esv_mem_model

//--- tb/tb_top.sv
// Self-checking bench for the exception status and vectoring unit.
// Assumes the behavioural memory model stands on the far side of the read port.
`timescale 1ns/100ps
module tb_top;
  import esv_pkg::*;
  localparam logic [11:0] TP    = 12'h123;
  localparam logic [7:0]  VP    = 8'h5A;
  localparam logic [15:0] FMASK = PSW_IRQ_MASK | (16'h0001 << PSW_SS_BIT) | (16'h0001 << PSW_USER_BIT);

  logic        clk, rst, entry_req, ret_req, psw_wr, mem_rvalid, mem_rd, mem_logical;
  logic        pc_load, fetch_go, fetch_uncached, m0_inject, priv_fault, busy;
  esv_src_t    entry_src;
  esv_ret_t    ret_kind;
  logic [1:0]  int_mode, pop_words;
  logic [2:0]  lat;
  logic [6:0]  irq_shadow;
  logic [9:0]  fixed_off;
  logic [15:0] ack_data, isr, sp, psw_wdata, mem_rdata, psw, pc, reason, p;
  logic [23:0] mem_addr;
  logic [23:0] la[$];
  int          errors, n_checks;

  esv_exception_unit i_esv_exception_unit (
    .clk(clk), .rst(rst), .entry_req(entry_req), .entry_src(entry_src), .int_mode(int_mode),
    .ack_data(ack_data), .fixed_off(fixed_off), .isr(isr), .vec_page(VP), .tbl_ptr(TP),
    .ret_req(ret_req), .ret_kind(ret_kind), .sp(sp), .psw_wr(psw_wr), .psw_wdata(psw_wdata),
    .irq_shadow(irq_shadow), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_logical(mem_logical), .psw(psw), .pc(pc), .pc_load(pc_load),
    .reason(reason), .fetch_go(fetch_go), .fetch_uncached(fetch_uncached), .m0_inject(m0_inject),
    .priv_fault(priv_fault), .pop_words(pop_words), .busy(busy));

  esv_mem_model i_esv_mem_model (
    .clk(clk), .rst(rst), .mem_rd(mem_rd), .mem_addr(mem_addr), .lat(lat),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (mem_rvalid === 1'b1) la.push_back(mem_addr);
  end

  function automatic logic [23:0] tba(input logic [9:0] o);
    return {TP, 12'h000} + {14'h0000, o};
  endfunction

  function automatic logic [15:0] sw(input logic [23:0] a);
    return {a[7:0], a[15:8]};
  endfunction

  task automatic err(input string msg);
    errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic c16(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) err($sformatf("value %h expected %h", g, e));
  endtask

  task automatic c24(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) err($sformatf("address %h expected %h", g, e));
  endtask

  // Waits for the first fetch, an injected instruction or a fault; a second entry can be sent while busy.
  task automatic wait_done(input bit dup);
    bit done;
    done = 1'b0;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge clk);
      entry_req <= dup && (i == 1);
      ret_req   <= 1'b0;
      #1;
      done = (fetch_go === 1'b1) || (m0_inject === 1'b1) || (priv_fault === 1'b1);
    end
    if (!done) err("no completion");
  endtask

  task automatic entry(input esv_src_t s, input logic [1:0] m, input logic [15:0] ack,
                       input logic [9:0] fo, input logic [15:0] is, input bit dup);
    @(posedge clk);
    la.delete();
    entry_req <= 1'b1;
    entry_src <= s;
    int_mode  <= m;
    ack_data  <= ack;
    fixed_off <= fo;
    isr       <= is;
    wait_done(dup);
  endtask

  task automatic ret(input esv_ret_t k);
    @(posedge clk);
    la.delete();
    ret_req  <= 1'b1;
    ret_kind <= k;
    sp       <= 16'h8000;
    wait_done(1'b0);
  endtask

  task automatic wr_psw(input logic [15:0] v);
    @(posedge clk);
    psw_wr    <= 1'b1;
    psw_wdata <= v;
    @(posedge clk);
    psw_wr    <= 1'b0;
    @(posedge clk);
    #1;
    c16(psw, v);
  endtask

  // Table entry: two reads in order, status word then counter, both done by the first fetch.
  task automatic tcase(input esv_src_t s, input logic [15:0] is, input logic [15:0] ack, input logic [9:0] fo,
                       input logic [9:0] pso, input logic [9:0] pco, input logic [15:0] rs, input bit dup);
    entry(s, 2'h3, ack, fo, is, dup);
    c16(16'(la.size()), 16'h0002);
    c24(la[0], tba(pso));
    c24(la[1], tba(pco));
    c16(psw, sw(tba(pso)));
    c16(pc, sw(tba(pco)));
    c16(pc_load, 16'h0001);
    c16(reason, rs);
    c16(mem_logical, 16'h0000);
    c16(mem_rd, 16'h0000);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; entry_req = 1'b0; ret_req = 1'b0; psw_wr = 1'b0; lat = 3'h1;
    entry_src = SRC_NMI; ret_kind = RET_NMI; int_mode = 2'h0; irq_shadow = 7'h55; fixed_off = 10'h000;
    ack_data = 16'h0000; isr = 16'h0000; sp = 16'h0000; psw_wdata = 16'h0000;
    errors = 0; n_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    c16(psw, PSW_RST);
    c16(busy, 16'h0000);
    wr_psw(16'h417F);
    entry(SRC_LINE_A, 2'h1, 16'h0000, 10'h000, 16'h0000, 1'b0);
    c16(pc, PC_MODE1);
    c16(psw & FMASK, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr_psw(16'h417F);
      entry(SRC_NMI, 2'(m), 16'h0000, 10'h000, 16'h0000, 1'b0);
      c16(pc, PC_NMI);
      c16(psw & FMASK, 16'h0000);
    end
    wr_psw(16'h007F);
    // A restart instruction stands in for the peripheral's own opcode.
    entry(SRC_LINE_A, 2'h0, 16'h00FF, 10'h000, 16'h0000, 1'b0);
    c16(m0_inject, 16'h0001);
    c16(pc_load, 16'h0000);
    c16(psw & FMASK, 16'h0000);
    entry(SRC_LINE_B, 2'h2, 16'h0034, 10'h000, 16'h0000, 1'b0);
    c24(la[0], {8'h00, VP, 8'h34});
    c16(pc, sw({8'h00, VP, 8'h34}));
    c16(mem_logical, 16'h0001);
    lat = 3'h3;
    tcase(SRC_LINE_A, 16'h0000, 16'h1234, 10'h000, 10'h008, 10'h00A, 16'h1234, 1'b1);
    tcase(SRC_LINE_A, 16'h2000, 16'h0034, 10'h000, 10'h008, 10'h0A4, 16'h0034, 1'b0);
    tcase(SRC_LINE_B, 16'h4000, 16'h0012, 10'h000, 10'h00C, 10'h182, 16'h0012, 1'b0);
    tcase(SRC_LINE_C, 16'h8000, 16'h00FE, 10'h000, 10'h010, 10'h36E, 16'h00FE, 1'b0);
    tcase(SRC_LINE_C, 16'h0000, 16'h0040, 10'h000, 10'h010, 10'h012, 16'h0040, 1'b0);
    tcase(SRC_NMI, 16'h2000, 16'h0008, 10'h000, 10'h004, 10'h078, 16'h0008, 1'b0);
    tcase(SRC_NMI, 16'h0000, 16'h0000, 10'h000, 10'h004, 10'h006, 16'h0000, 1'b0);
    tcase(SRC_ONCHIP, 16'h0000, 16'h0000, 10'h014, 10'h014, 10'h016, 16'h0014, 1'b0);
    tcase(SRC_TRAP, 16'h0000, 16'h0000, 10'h03C, 10'h03C, 10'h03E, 16'h003C, 1'b1);
    p = psw;
    ret(RET_NMI);
    c24(la[0], 24'h008000);
    c16(pc, 16'h0080);
    c16(psw, {p[15:7], 7'h55});
    c16(pop_words, 16'h0001);
    c16(fetch_uncached, 16'h0000);
    p = psw;
    ret(RET_MASKABLE);
    c16(pc, 16'h0080);
    c16(psw, p);
    c16(fetch_uncached, 16'h0001);
    // The stack holds only the status word and counter, as a routine that dropped its trap data leaves it.
    ret(RET_LONG);
    c24(la[1], 24'h008002);
    c16(psw, 16'h0080);
    c16(pc, 16'h0280);
    c16(pop_words, 16'h0002);
    c16(fetch_uncached, 16'h0000);
    lat = 3'h1;
    wr_psw(16'h4000);
    for (int k = 0; k < 3; k++) begin
      p = pc;
      ret(esv_ret_t'(k));
      c16(priv_fault, 16'h0001);
      c16(pc, p);
      c16(16'(la.size()), 16'h0000);
    end
    finish_test();
  end
endmodule // tb_top
